// file: inc/nesg_pkg.sv
// Constants for the NAND page ECC segment locator block.
// Assumes a 32-bit AXI4-Lite register bus and a 4096-byte page stream.
package nesg_pkg;
    // Segment geometry
    localparam int SEG_COUNT = 6;
    localparam int SEG_FIRST = 10;
    localparam int SEG_BYTES = 256;
    localparam int PAGE_ADDR_W = 12;
    localparam int SEG_IDX_W = 4;
    localparam int REF_SEL_W = 3;

    // Segment register layout
    localparam int BIT_LSB = 0;
    localparam int BIT_W = 3;
    localparam int WORD_LSB = 3;
    localparam int WORD_W = 8;
    localparam int PAR_LSB = 12;
    localparam int PAR_W = 11;
    localparam logic [PAR_W-1:0] PAR_RESET = 11'h000;

    // Register byte offsets
    localparam logic [7:0] OFF_SEG_BASE = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_ENABLE = 8'h1c;
    localparam logic [7:0] OFF_CLEAR = 8'h20;
    localparam int ADDR_W = 8;

    // Status layout: single-error flags low, multi-error flags high
    localparam int EVT_W = 2 * SEG_COUNT;
    localparam int EVT_MULTI_LSB = SEG_COUNT;
    localparam logic [EVT_W-1:0] EVT_RESET = 12'h000;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef logic [31:0] nesg_word_t;
endpackage

// file: inc/nesg_seg_if.sv
// Signals between the top and one segment checker.
// Assumes the top drives the stream side and reads the result side.
`timescale 1ns/1ps
interface nesg_seg_if;
    import nesg_pkg::*;
    logic clear;
    logic byte_valid;
    logic [PAGE_ADDR_W-1:0] byte_addr;
    logic [7:0] byte_data;
    logic check;
    logic [PAR_W-1:0] ref_parity;
    logic ref_odd;
    nesg_word_t reg_word;
    logic single_err;
    logic multi_err;

    modport top (output clear, byte_valid, byte_addr, byte_data, check, ref_parity, ref_odd,
                 input reg_word, single_err, multi_err);
    modport seg (input clear, byte_valid, byte_addr, byte_data, check, ref_parity, ref_odd,
                 output reg_word, single_err, multi_err);
endinterface // nesg_seg_if

// file: rtl/nesg_segment.sv
// One 256-byte segment: parity accumulator and single-bit error locator.
// Assumes the top gates clear, stream and check pulses on sys_clk.
`timescale 1ns/1ps
module nesg_segment #(
    parameter logic [nesg_pkg::SEG_IDX_W-1:0] SEG_IDX = 4'ha
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Link to top
    nesg_seg_if.seg link
);
    import nesg_pkg::*;

    logic [PAR_W-1:0] parity;
    logic odd;
    logic [BIT_W-1:0] bit_pos;
    logic [WORD_W-1:0] byte_loc;
    logic [PAR_W-1:0] next_parity;
    logic next_odd;
    logic [PAR_W-1:0] syndrome;
    logic mismatch;
    logic in_seg;

    assign in_seg = link.byte_valid && (link.byte_addr[PAGE_ADDR_W-1:WORD_W] == SEG_IDX);
    assign syndrome = parity ^ link.ref_parity;
    assign mismatch = odd ^ link.ref_odd;

    // Each set bit folds its in-segment position into the parity
    always_comb begin
        next_parity = parity;
        next_odd = odd;
        for (int i = 0; i < 8; i++) begin
            if (link.byte_data[i]) begin
                next_parity = next_parity ^ {link.byte_addr[WORD_W-1:0], BIT_W'(i)};
                next_odd = ~next_odd;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            parity <= PAR_RESET;
            odd <= 1'b0;
        end else if (link.clear) begin
            parity <= PAR_RESET;
            odd <= 1'b0;
        end else if (in_seg) begin
            parity <= next_parity;
            odd <= next_odd;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bit_pos <= '0;
            byte_loc <= '0;
        end else if (link.clear) begin
            bit_pos <= '0;
            byte_loc <= '0;
        end else if (link.check) begin
            bit_pos <= syndrome[BIT_W-1:0];
            byte_loc <= syndrome[PAR_W-1:BIT_W];
        end
    end

    // Odd flip count with any syndrome means one flipped bit
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            link.single_err <= 1'b0;
            link.multi_err <= 1'b0;
        end else begin
            link.single_err <= link.check && mismatch;
            link.multi_err <= link.check && !mismatch && (syndrome != '0);
        end
    end

    always_comb begin
        link.reg_word = '0;
        link.reg_word[BIT_LSB +: BIT_W] = bit_pos;
        link.reg_word[WORD_LSB +: WORD_W] = byte_loc;
        link.reg_word[PAR_LSB +: PAR_W] = parity;
    end
endmodule // nesg_segment

// file: rtl/nesg_top.sv
// NAND page ECC, upper segment registers with AXI4-Lite access.
// Assumes a byte stream with page addresses and spare-area parity words on sys_clk.
//
// Function
// - Single error: report bit offset in byte
// - Single error: report address of 8-bit word
// - Multiple errors: location fields meaningless, ignore
// - Six registers cover bytes 2560 to 4095
//
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module nesg_top (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // AXI4-Lite write address
    input wire logic [nesg_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [nesg_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Page data stream
    input wire logic page_start,
    input wire logic byte_valid,
    input wire logic [nesg_pkg::PAGE_ADDR_W-1:0] byte_addr,
    input wire logic [7:0] byte_data,
    // Stored parity read back from spare area
    input wire logic ref_valid,
    input wire logic [nesg_pkg::REF_SEL_W-1:0] ref_seg,
    input wire logic [nesg_pkg::PAR_W-1:0] ref_parity,
    input wire logic ref_odd,
    // Interrupt
    output logic irq
);
    import nesg_pkg::*;

    logic [SEG_COUNT-1:0] seg_single;
    logic [SEG_COUNT-1:0] seg_multi;
    nesg_word_t seg_word [SEG_COUNT];

    logic [EVT_W-1:0] status;
    logic [EVT_W-1:0] enable;
    logic [EVT_W-1:0] clear_mask;
    logic [EVT_W-1:0] events;
    logic [EVT_W-1:0] next_status;

    logic aw_have;
    logic w_have;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic wr_hit;
    logic [31:0] rd_value;
    logic rd_hit;

    for (genvar g = 0; g < SEG_COUNT; g++) begin : g_seg
        nesg_seg_if link ();

        assign link.clear = page_start;
        assign link.byte_valid = byte_valid;
        assign link.byte_addr = byte_addr;
        assign link.byte_data = byte_data;
        assign link.check = ref_valid && (ref_seg == REF_SEL_W'(g));
        assign link.ref_parity = ref_parity;
        assign link.ref_odd = ref_odd;
        assign seg_word[g] = link.reg_word;
        assign seg_single[g] = link.single_err;
        assign seg_multi[g] = link.multi_err;

        nesg_segment #(
            .SEG_IDX(SEG_IDX_W'(SEG_FIRST + g))
        ) u_seg (
            .sys_clk(sys_clk),
            .rst(rst),
            .link(link)
        );
    end

    assign events = {seg_multi, seg_single};

    // Write decode; writes to read-only words are accepted and dropped
    assign do_write = aw_have && w_have && !s_axi_bvalid;
    always_comb begin
        wr_hit = 1'b0;
        clear_mask = '0;
        if (aw_addr < OFF_STATUS && aw_addr[1:0] == 2'h0) begin
            wr_hit = 1'b1;
        end
        if (aw_addr == OFF_STATUS || aw_addr == OFF_ENABLE) begin
            wr_hit = 1'b1;
        end
        if (aw_addr == OFF_CLEAR) begin
            wr_hit = 1'b1;
            if (do_write) begin
                clear_mask[7:0] = w_strb[0] ? w_data[7:0] : 8'h00;
                clear_mask[EVT_W-1:8] = w_strb[1] ? w_data[EVT_W-1:8] : 4'h0;
            end
        end
    end

    // Set wins over clear in the same cycle
    assign next_status = (status & ~clear_mask) | events;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            status <= EVT_RESET;
        end else begin
            status <= next_status;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            enable <= EVT_RESET;
        end else if (do_write && aw_addr == OFF_ENABLE) begin
            if (w_strb[0]) begin
                enable[7:0] <= w_data[7:0];
            end
            if (w_strb[1]) begin
                enable[EVT_W-1:8] <= w_data[EVT_W-1:8];
            end
        end
    end

    // Registered so the pin is glitch-free; follows enable writes one cycle late
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_status & enable);
        end
    end

    // Write address channel
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            aw_have <= 1'b0;
            aw_addr <= '0;
            s_axi_awready <= 1'b1;
        end else if (s_axi_bvalid && s_axi_bready) begin
            aw_have <= 1'b0;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
    end

    // Write data channel
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            w_have <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_bvalid && s_axi_bready) begin
            w_have <= 1'b0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
    end

    // Write response
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read mux; clear word reads as zero
    always_comb begin
        rd_value = '0;
        rd_hit = 1'b0;
        if (s_axi_araddr < OFF_STATUS && s_axi_araddr[1:0] == 2'h0) begin
            rd_hit = 1'b1;
            rd_value = seg_word[s_axi_araddr[4:2]];
        end else if (s_axi_araddr == OFF_STATUS) begin
            rd_hit = 1'b1;
            rd_value[EVT_W-1:0] = status;
        end else if (s_axi_araddr == OFF_ENABLE) begin
            rd_hit = 1'b1;
            rd_value[EVT_W-1:0] = enable;
        end else if (s_axi_araddr == OFF_CLEAR) begin
            rd_hit = 1'b1;
        end
    end

    // Read channel, one outstanding read
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_value;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule // nesg_top

// file: bench/nesg_top_props.sv
// Port checker for the segment ECC block.
// Assumes it is bound into nesg_top.
`timescale 1ns/1ps
module nesg_top_props import nesg_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic [ADDR_W-1:0] rd_addr;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) rd_addr <= '0;
        else if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr;
    end
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered next cycle");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    // Both halves are latched first, so the response shows one edge later
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> ##1 s_axi_bvalid)
        else $error("write not answered");
    // Unaligned words below status are refused, so only aligned reads count
    a_seg_layout: assert property (s_axi_rvalid && rd_addr < OFF_STATUS && rd_addr[1:0] == 2'h0
        |-> s_axi_rdata[31:23] == 9'h000 && !s_axi_rdata[11] && s_axi_rresp == RESP_OKAY)
        else $error("segment word layout wrong");
    a_map_error: assert property (s_axi_rvalid && rd_addr > OFF_CLEAR |-> s_axi_rresp == RESP_SLVERR)
        else $error("unmapped read not refused");
endmodule // nesg_top_props
bind nesg_top nesg_top_props nesg_top_props_i (.sys_clk, .rst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// file: bench/nesg_page_model.sv
// Page data path model: byte stream and stored parity.
// Assumes the bench calls its tasks.
`timescale 1ns/1ps
module nesg_page_model import nesg_pkg::*; (
    // Clock
    input wire logic sys_clk,
    // Stream
    output logic page_start,
    output logic byte_valid,
    output logic [PAGE_ADDR_W-1:0] byte_addr,
    output logic [7:0] byte_data,
    // Stored parity
    output logic ref_valid,
    output logic [REF_SEL_W-1:0] ref_seg,
    output logic [PAR_W-1:0] ref_parity,
    output logic ref_odd
);
    initial begin
        {page_start, byte_valid, ref_valid, ref_odd} = 4'h0;
        {byte_addr, byte_data, ref_seg, ref_parity} = '0;
    end
    task automatic pulse_start();
        @(posedge sys_clk) page_start <= 1'b1;
        @(posedge sys_clk) page_start <= 1'b0;
    endtask
    task automatic put_byte(input logic [PAGE_ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        {byte_valid, byte_addr, byte_data} <= {1'b1, a, d};
        @(posedge sys_clk);
        // Stale data would hide a missing strobe check
        {byte_valid, byte_addr, byte_data} <= {1'b0, ~a, ~d};
    endtask
    task automatic check_seg(input logic [REF_SEL_W-1:0] s, input logic [PAR_W-1:0] p, input logic o);
        @(posedge sys_clk);
        {ref_valid, ref_seg, ref_parity, ref_odd} <= {1'b1, s, p, o};
        @(posedge sys_clk);
        {ref_valid, ref_seg, ref_parity, ref_odd} <= {1'b0, ~s, ~p, ~o};
    endtask
endmodule // nesg_page_model

// file: bench/tb_top.sv
// Bench for the segment ECC block.
// Assumes the page model and the bound checker.
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
    $display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module tb_top;
    import nesg_pkg::*;
    logic sys_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq, page_start, byte_valid, ref_valid, ref_odd;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [PAGE_ADDR_W-1:0] byte_addr;
    logic [7:0] byte_data;
    logic [REF_SEL_W-1:0] ref_seg;
    logic [PAR_W-1:0] ref_parity, loc;
    int error_cnt = 0;
    int cmp_count = 0;
    nesg_word_t got;
    nesg_top nesg_top_i (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .page_start, .byte_valid, .byte_addr, .byte_data, .ref_valid, .ref_seg,
        .ref_parity, .ref_odd, .irq);
    nesg_page_model nesg_page_model_i (.sys_clk, .page_start, .byte_valid, .byte_addr, .byte_data,
        .ref_valid, .ref_seg, .ref_parity, .ref_odd);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic final_report();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input nesg_word_t d, input logic [1:0] r);
        @(posedge sys_clk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
        do begin
            @(posedge sys_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, r)
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [1:0] r);
        @(posedge sys_clk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do begin
            @(posedge sys_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        got = s_axi_rdata;
        `CHK(s_axi_rresp, r)
    endtask
    initial begin
        rst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        rd(8'h40, RESP_SLVERR);
        rd(8'h02, RESP_SLVERR);
        wr(8'h40, 32'h0, RESP_SLVERR);
        wr(OFF_SEG_BASE, 32'hffffffff, RESP_OKAY);
        wr(OFF_ENABLE, 32'hfff, RESP_OKAY);
        nesg_page_model_i.pulse_start();
        nesg_page_model_i.put_byte(12'h9ff, 8'h01);
        for (int i = 0; i < SEG_COUNT; i++) nesg_page_model_i.put_byte(12'ha00 + 12'(307 * i), 8'h01 << i);
        for (int i = 0; i < SEG_COUNT; i++) begin
            loc = {8'(51 * i), 3'(i)};
            rd(8'(4 * i), RESP_OKAY);
            `CHK(got, {9'h0, loc, 12'h000})
            nesg_page_model_i.check_seg(3'(i), 11'h000, 1'b0);
            rd(8'(4 * i), RESP_OKAY);
            `CHK(got, {9'h0, loc, 1'b0, loc})
        end
        rd(OFF_STATUS, RESP_OKAY);
        `CHK(got, 32'h03f)
        `CHK(irq, 1'b1)
        wr(OFF_CLEAR, 32'hfff, RESP_OKAY);
        wr(OFF_ENABLE, 32'h0, RESP_OKAY);
        nesg_page_model_i.pulse_start();
        nesg_page_model_i.put_byte(12'ha00, 8'h03);
        nesg_page_model_i.check_seg(3'h0, 11'h000, 1'b0);
        rd(OFF_SEG_BASE, RESP_OKAY);
        `CHK(got[22:12], 11'h001)
        rd(OFF_STATUS, RESP_OKAY);
        `CHK(got, 32'h040)
        `CHK(irq, 1'b0)
        wr(OFF_ENABLE, 32'hfff, RESP_OKAY);
        repeat (3) @(posedge sys_clk);
        `CHK(irq, 1'b1)
        wr(OFF_CLEAR, 32'hfff, RESP_OKAY);
        repeat (3) @(posedge sys_clk);
        `CHK(irq, 1'b0)
        // Upper lane only: low enable byte must survive
        s_axi_wstrb <= 4'h2;
        wr(OFF_ENABLE, 32'h0, RESP_OKAY);
        rd(OFF_ENABLE, RESP_OKAY);
        `CHK(got, 32'h0ff)
        s_axi_wstrb <= 4'hf;
        nesg_page_model_i.pulse_start();
        rd(OFF_SEG_BASE, RESP_OKAY);
        `CHK(got, 32'h0)
        final_report();
    end
    initial begin
        #100000;
        error_cnt++;
        final_report();
    end
endmodule // tb_top
